// >>> periodic_timebase_interrupt.sv
// periodic timebase interrupt generator with control register port
// Notes on behaviour
// - chain overflow at selected tap sets the pending flag
// - with interrupt enable set, a set pending flag requests the cpu
// - ack one clears flag, ack zero ignored, ack reads zero
// - pending flag is read only and shows pending state
// - without prescale, codes select 32768 8192 2048 128 64 32 16 8
// - with prescale, codes select 4194304 down to 1024 as tabled
// - period is divide ratio over oscillator clock frequency
// - enable low clears chain, enable high counts, reset clears enable
// - interrupt enable is read/write, gates request only, reset clears it
// - wait mode keeps counting, flagging and requesting
// - control register is not reachable by the cpu in wait mode
// - stop mode runs only if oscillator kept alive, else halts
// - running in stop, enabled tick wakes the device
// - control register is not reachable by the cpu in stop mode
// - first flag after enable near half period, later at exact period
`timescale 1ns/100ps
module periodic_timebase_interrupt
    import tick_pkg::*;
#(
    parameter int CHAIN_WIDTH = CHAIN_W
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire logic [1:0] power_mode,
    input wire logic extra_prescale_option,
    input wire logic osc_keep_alive_in_stop,
    output logic tick_irq,
    output logic tick_wakeup,
    output logic irq
);
    if (CHAIN_WIDTH < 16) begin : g_width_check
        $error("chain too short for the divide taps");
    end

    logic tick_enable_q;
    logic tick_irq_enable_q;
    logic [RATE_W-1:0] tick_rate_select_q;
    logic tick_pending_flag_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] mask_q;
    logic [CHAIN_WIDTH-1:0] chain_q;
    logic [DATA_W-1:0] rdata_q;
    logic tick_irq_q;
    logic tick_wakeup_q;
    logic irq_q;
    logic in_wait;
    logic in_stop;
    logic osc_alive;
    logic cpu_access;
    logic ctrl_wr;
    logic stat_wr;
    logic mask_wr;
    logic step;
    logic overflow;
    logic ack;
    logic [4:0] tap;

    always_comb begin
        in_wait = power_mode == 2'(mode_wait);
        in_stop = power_mode == 2'(mode_stop);
        osc_alive = !in_stop || osc_keep_alive_in_stop;
        cpu_access = !in_wait && !in_stop;
        ctrl_wr = wr_en && cpu_access && addr == CTRL_OFFS;
        stat_wr = wr_en && addr == IRQ_STAT_OFFS;
        mask_wr = wr_en && addr == IRQ_MASK_OFFS;
        ack = ctrl_wr && wdata[ACK_BIT];
        // bit below the ratio's power: its rising edge repeats once per divide ratio
        tap = 5'(tap_log2(tick_rate_select_q) - 5'h1);
    end

    // control register fields
    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_enable_q <= 1'b0;
            tick_irq_enable_q <= 1'b0;
            tick_rate_select_q <= '0;
        end else if (ctrl_wr) begin
            tick_enable_q <= wdata[ENABLE_BIT];
            tick_irq_enable_q <= wdata[IRQ_EN_BIT];
            // rate kept steady by software while enabled
            tick_rate_select_q <= wdata[RATE_LSB +: RATE_W];
        end
    end

    // chain steps every oscillator cycle, or every 128th one with the extra prescale option
    tick_prescaler u_prescaler (
        .mclk(mclk),
        .reset(reset),
        .run(tick_enable_q && osc_alive),
        .clear(!tick_enable_q),
        .bypass(!extra_prescale_option),
        .step(step)
    );

    always_ff @(posedge mclk) begin
        if (reset || !tick_enable_q) begin
            chain_q <= '0;
        end else if (step) begin
            chain_q <= chain_q + 1'b1;
        end
    end

    // tap rises first after half a period, then once every full period
    tick_edge_detect #(
        .WIDTH(CHAIN_WIDTH)
    ) u_edge (
        .mclk(mclk),
        .reset(reset),
        .clear(!tick_enable_q),
        .step(step),
        .chain(chain_q),
        .tap(tap),
        .overflow(overflow)
    );

    // set wins over acknowledge
    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_pending_flag_q <= 1'b0;
        end else if (overflow) begin
            tick_pending_flag_q <= 1'b1;
        end else if (ack) begin
            tick_pending_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            stat_q <= '0;
        end else begin
            for (int i = 0; i < EV_W; i++) begin
                if (i == EV_TICK_BIT && overflow) begin
                    stat_q[i] <= 1'b1;
                end else if (stat_wr && wdata[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mask_q <= '0;
        end else if (mask_wr) begin
            mask_q <= wdata[EV_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_irq_q <= 1'b0;
            tick_wakeup_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // mirrors the flag's next value so a tick beside an ack leaves no gap
            tick_irq_q <= tick_irq_enable_q && (overflow || (tick_pending_flag_q && !ack));
            tick_wakeup_q <= in_stop && osc_keep_alive_in_stop && tick_irq_enable_q && overflow;
            irq_q <= |(stat_q & mask_q);
        end
    end

    // read port; ack bit and reserved bits read zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= UNMAPPED_READ;
        end else if (rd_en) begin
            case (addr)
                CTRL_OFFS: begin
                    rdata_q <= CTRL_RESET;
                    if (cpu_access) begin
                        rdata_q[FLAG_BIT] <= tick_pending_flag_q;
                        rdata_q[RATE_LSB +: RATE_W] <= tick_rate_select_q;
                        rdata_q[IRQ_EN_BIT] <= tick_irq_enable_q;
                        rdata_q[ENABLE_BIT] <= tick_enable_q;
                    end
                end
                IRQ_STAT_OFFS: rdata_q <= DATA_W'(stat_q);
                IRQ_MASK_OFFS: rdata_q <= DATA_W'(mask_q);
                default: rdata_q <= UNMAPPED_READ;
            endcase
        end else begin
            rdata_q <= UNMAPPED_READ;
        end
    end

    assign rdata = rdata_q;
    assign tick_irq = tick_irq_q;
    assign tick_wakeup = tick_wakeup_q;
    assign irq = irq_q;
endmodule : periodic_timebase_interrupt

// >>> periodic_timebase_interrupt_sva.sv
// port assertions for the periodic timebase block
`timescale 1ns/100ps
module periodic_timebase_interrupt_sva
    import tick_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] power_mode,
    input wire logic extra_prescale_option,
    input wire logic osc_keep_alive_in_stop,
    input wire logic tick_irq,
    input wire logic tick_wakeup,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_quiet_wr;
        wr_en && addr == CTRL_OFFS && power_mode == mode_run && !wdata[IRQ_EN_BIT];
    endsequence
    a_reset_quiet: assert property ($fell(reset) |-> !irq && !tick_irq && !tick_wakeup)
        else $error("active after reset");
    a_ack_zero: assert property (rd_en && addr == CTRL_OFFS |=> !rdata[ACK_BIT])
        else $error("ack reads one");
    a_wait_blank: assert property (rd_en && addr == CTRL_OFFS && power_mode == mode_wait |=> rdata == 8'h00)
        else $error("read in wait");
    a_stop_blank: assert property (rd_en && addr == CTRL_OFFS && power_mode == mode_stop |=> rdata == 8'h00)
        else $error("read in stop");
    // two edges: control register first, then the registered request
    a_ien_gate: assert property (s_quiet_wr |-> ##2 !tick_irq)
        else $error("request without enable");
    a_mask_gate: assert property (wr_en && addr == IRQ_MASK_OFFS && !wdata[EV_TICK_BIT] |-> ##2 !irq)
        else $error("irq while masked");
    a_wake_stop: assert property (tick_wakeup |->
        osc_keep_alive_in_stop && $past(power_mode) == mode_stop)
        else $error("wakeup outside stop");
    a_wake_pulse: assert property (tick_wakeup |=> !tick_wakeup)
        else $error("wakeup held");
endmodule : periodic_timebase_interrupt_sva

bind periodic_timebase_interrupt periodic_timebase_interrupt_sva chk_i (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .power_mode(power_mode), .extra_prescale_option(extra_prescale_option),
    .osc_keep_alive_in_stop(osc_keep_alive_in_stop), .tick_irq(tick_irq), .tick_wakeup(tick_wakeup), .irq(irq)
);

// >>> periodic_timebase_interrupt_tb.sv
// self-checking bench for the periodic timebase block
`timescale 1ns/100ps
module periodic_timebase_interrupt_tb
    import tick_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] power_mode = 2'h0;
    logic extra_prescale_option = 1'b0;
    logic osc_keep_alive_in_stop = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic tick_irq, tick_wakeup, irq;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    periodic_timebase_interrupt uut (
        .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .power_mode(power_mode), .extra_prescale_option(extra_prescale_option),
        .osc_keep_alive_in_stop(osc_keep_alive_in_stop), .tick_irq(tick_irq), .tick_wakeup(tick_wakeup), .irq(irq)
    );
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %0h seen %0h", n, e, g);
            mismatches++;
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rck(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rck
    // waits on tick_irq (0), irq (1) or tick_wakeup (2); the cycle ceiling bounds it
    task automatic wt(input int s, output int t);
        do begin
            @(posedge mclk);
            #1;
        end while ((s == 0 ? tick_irq : s == 1 ? irq : tick_wakeup) !== 1'b1);
        t = cyc;
    endtask : wt
    // disabling write also acks, so a stale flag cannot fake the first tick
    task automatic t_rate(input logic p, input logic [2:0] c, input int lg);
        int t0, t1;
        wr(CTRL_OFFS, 8'h08);
        extra_prescale_option <= p;
        wr(CTRL_OFFS, {1'b0, c, 4'h6});
        wt(0, t0);
        wr(CTRL_OFFS, {1'b0, c, 4'hE});
        wt(0, t1);
        chk("period", 1 << lg, t1 - t0);
    endtask : t_rate
    task automatic t_rates();
        rck("ctrl reset", CTRL_OFFS, CTRL_RESET);
        rck("unmapped", 4'hF, UNMAPPED_READ);
        for (int c = 1; c < 8; c++) t_rate(1'b0, 3'(c), c < 3 ? 15 - 2 * c : 10 - c);
        for (int c = 4; c < 8; c++) t_rate(1'b1, 3'(c), 17 - c);
    endtask : t_rates
    task automatic t_flag();
        int t;
        wr(CTRL_OFFS, 8'h08);
        extra_prescale_option <= 1'b0;
        wr(IRQ_STAT_OFFS, 8'h01);
        wr(IRQ_MASK_OFFS, 8'h01);
        wr(CTRL_OFFS, 8'h32);
        wt(1, t);
        chk("gated", 0, tick_irq);
        rck("flag", CTRL_OFFS, 8'hB2);
        wr(CTRL_OFFS, 8'h32);
        rck("ack zero", CTRL_OFFS, 8'hB2);
        wr(CTRL_OFFS, 8'h3A);
        rck("ack one", CTRL_OFFS, 8'h32);
        wr(IRQ_MASK_OFFS, 8'h00);
        rck("status", IRQ_STAT_OFFS, 8'h01);
        chk("masked", 0, irq);
        wr(IRQ_STAT_OFFS, 8'h01);
        rck("cleared", IRQ_STAT_OFFS, 8'h00);
    endtask : t_flag
    // slowest plain rate: only the first, half-period tick fits the run
    task automatic t_slowest();
        int t0, t1;
        wr(CTRL_OFFS, 8'h38);
        wr(CTRL_OFFS, 8'h06);
        t0 = cyc;
        wt(0, t1);
        chk("rate 0 first tick", 1, t1 - t0 >= 32768 / 2 && t1 - t0 <= 32768 / 2 + 8);
    endtask : t_slowest
    task automatic t_restart();
        int t0, t1, t2, t3;
        wr(CTRL_OFFS, 8'h38);
        t0 = cyc;
        wr(CTRL_OFFS, 8'h36);
        wt(0, t1);
        repeat (40) @(posedge mclk);
        wr(CTRL_OFFS, 8'h38);
        t2 = cyc;
        wr(CTRL_OFFS, 8'h36);
        wt(0, t3);
        chk("restart", t1 - t0, t3 - t2);
        chk("first tick", 1, t1 - t0 <= 128 / 2 + 8);
    endtask : t_restart
    task automatic t_wait();
        int t;
        wr(CTRL_OFFS, 8'h3E);
        wr(IRQ_MASK_OFFS, 8'h01);
        power_mode <= mode_wait;
        rck("wait read", CTRL_OFFS, 8'h00);
        wr(CTRL_OFFS, 8'h00);
        wr(IRQ_STAT_OFFS, 8'h01);
        wt(1, t);
        @(posedge mclk);
        power_mode <= mode_run;
        rck("after wait", CTRL_OFFS, 8'hB6);
    endtask : t_wait
    task automatic t_stop();
        int t, ts;
        @(posedge mclk);
        power_mode <= mode_stop;
        rck("stop read", CTRL_OFFS, 8'h00);
        wr(IRQ_STAT_OFFS, 8'h01);
        repeat (300) @(posedge mclk);
        #1;
        chk("halted", 0, irq);
        @(posedge mclk);
        osc_keep_alive_in_stop <= 1'b1;
        ts = cyc;
        wt(2, t);
        chk("wakeup", 1, t - ts <= 128 + 4);
        @(posedge mclk);
        power_mode <= mode_run;
    endtask : t_stop
    // disabled timebase stays silent in standby; a mid-run reset clears the enables
    task automatic t_reset();
        int t;
        wr(CTRL_OFFS, 8'h08);
        wr(IRQ_STAT_OFFS, 8'h01);
        power_mode <= mode_wait;
        repeat (300) @(posedge mclk);
        #1;
        chk("idle wait", 0, irq);
        @(posedge mclk);
        power_mode <= mode_run;
        wr(CTRL_OFFS, 8'h36);
        wt(0, t);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rck("reset ctrl", CTRL_OFFS, CTRL_RESET);
        chk("reset irq", 0, tick_irq);
    endtask : t_reset
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_rates();
        t_flag();
        t_slowest();
        t_restart();
        t_wait();
        t_stop();
        t_reset();
        tally_and_finish();
    end
endmodule : periodic_timebase_interrupt_tb

// >>> tick_edge_detect.sv
// detects the rising transition of the chosen chain tap
`timescale 1ns/100ps
module tick_edge_detect #(
    parameter int WIDTH = 22
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clear,
    input wire logic step,
    input wire logic [WIDTH-1:0] chain,
    input wire logic [4:0] tap,
    output logic overflow
);
    logic prev_q;
    logic cur;

    always_comb begin
        cur = chain[tap];
    end

    // each rise of the tap ends one period of the tap and the stages below it; the first rise comes after half a period
    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            prev_q <= 1'b0;
        end else if (step) begin
            prev_q <= cur;
        end
    end

    always_comb begin
        // qualified by step so a slow prescaled chain still gives a one-cycle pulse
        overflow = step && !prev_q && cur;
    end
endmodule : tick_edge_detect

// >>> tick_pkg.sv
// constants for the periodic timebase block
package tick_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFS = 4'h0;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFFS = 4'h1;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFS = 4'h2;
    // timebase_control layout
    localparam int FLAG_BIT = 7;
    localparam int RATE_LSB = 4;
    localparam int RATE_W = 3;
    localparam int ACK_BIT = 3;
    localparam int IRQ_EN_BIT = 2;
    localparam int ENABLE_BIT = 1;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    // status / mask layout
    localparam int EV_TICK_BIT = 0;
    localparam int EV_W = 1;
    // chain geometry
    localparam int CHAIN_W = 22;
    localparam int PRESCALE_SHIFT = 7;
    localparam int PRESCALE_LAST = 127;
    typedef enum logic [1:0] {
        mode_run,
        mode_wait,
        mode_stop
    } power_mode_e;
    // log2 of the base divide ratio for each rate code
    function automatic logic [4:0] tap_log2(input logic [RATE_W-1:0] code);
        case (code)
            3'h0: tap_log2 = 5'hF;
            3'h1: tap_log2 = 5'hD;
            3'h2: tap_log2 = 5'hB;
            3'h3: tap_log2 = 5'h7;
            3'h4: tap_log2 = 5'h6;
            3'h5: tap_log2 = 5'h5;
            3'h6: tap_log2 = 5'h4;
            default: tap_log2 = 5'h3;
        endcase
    endfunction : tap_log2
endpackage : tick_pkg

// >>> tick_prescaler.sv
// optional divide-by-128 enable pulse generator
`timescale 1ns/100ps
module tick_prescaler
    import tick_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic clear,
    input wire logic bypass,
    output logic step
);
    logic [PRESCALE_SHIFT-1:0] count_q;

    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            count_q <= '0;
        end else if (run && !bypass) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_comb begin
        step = run && (bypass || count_q == PRESCALE_SHIFT'(PRESCALE_LAST));
    end
endmodule : tick_prescaler
